/* scc_clock_source.sv */
// Added by the designer: the address map and the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Contract
// - Option setting chooses crystal/ceramic or external RC as high-speed source.
// - Option setting decides whether software may stop the internal oscillator.
// - Internal oscillator always starts after reset release, typically 240 kHz.
// - Prescaler clock follows the source currently feeding the CPU.
// - Reset clears the CPU clock select bit, selecting the internal oscillator.
// - CPU clock withheld for 17 internal oscillator clocks after reset release.
// - Both oscillators stay stopped while reset is asserted.
// - Status bit shows which source the CPU actually runs from.
// - Internal stop bit works only if option allows and CPU runs high-speed.
// - Main oscillator control stops high-speed oscillator while CPU runs internal.
// - STOP release on high-speed source waits selected 2^11..2^16 periods.
// - CPU starts from internal oscillator without high-speed stabilization wait.
// - Clock monitor detects high-speed stop; CPU falls back to internal clock.
// - Stabilization status bits set in order, shortest first, and clear on STOP or main oscillator stop.
// - After select rewrite, old clock runs a few cycles before switching.
module scc_clock_source (
  input  wire logic        clock,
  input  wire logic        reset,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic             hresp,
  output logic [31:0]      hrdata,
  // Resonators and option settings
  input  wire logic        hsOscIn,
  input  wire logic        intOscIn,
  input  wire logic        optRcSelect,
  input  wire logic        optIntOscLocked,
  output logic             hsXtalEnable,
  output logic             hsRcEnable,
  output logic             intOscEnable,
  // CPU side
  input  wire logic        stopMode,
  output logic             cpuClk,
  output logic             prescalerClk,
  output logic             cpuClkRun,
  output logic             hsClockFail
);
  import scc_pkg::*;

  // ------------------------------------------------------------
  // Input synchronisers
  // ------------------------------------------------------------
  logic [3:0]  rawIn;
  logic [3:0]  syncA;
  logic [3:0]  syncB;
  logic        hsLvl;
  logic        intLvl;
  logic        rcSel;
  logic        intLocked;
  logic        hsPrev;
  logic        intPrev;
  logic        hsRise;
  logic        intRise;

  assign rawIn = {optIntOscLocked, optRcSelect, intOscIn, hsOscIn};

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : gSync
      // Two-stage capture of each outside level
      always_ff @(posedge clock) begin
        if (reset) begin
          syncA[gi] <= 1'b0;
          syncB[gi] <= 1'b0;
        end else begin
          syncA[gi] <= rawIn[gi];
          syncB[gi] <= syncA[gi];
        end
      end
    end
  endgenerate

  assign hsLvl     = syncB[0];
  assign intLvl    = syncB[1];
  assign rcSel     = syncB[2];
  assign intLocked = syncB[3];

  // Edge history of the sampled oscillators
  always_ff @(posedge clock) begin
    if (reset) begin
      hsPrev  <= 1'b0;
      intPrev <= 1'b0;
    end else begin
      hsPrev  <= hsLvl;
      intPrev <= intLvl;
    end
  end

  assign hsRise  = hsLvl & ~hsPrev;
  assign intRise = intLvl & ~intPrev;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  logic        selBit;
  logic        intStop;
  logic        mainStop;
  logic [2:0]  stabSel;
  logic        curSrc;
  logic [4:0]  stabStatus;
  logic        wrPend;
  logic [31:0] wrAddr;
  logic        addrTaken;
  logic        wrMode;
  logic        wrIntOsc;
  logic        wrMainOsc;
  logic        wrStabSel;
  logic [31:0] rdValue;

  assign addrTaken = hsel & htrans[1] & hready;
  assign wrMode    = wrPend & regHit(wrAddr, MAIN_CLOCK_MODE_IDX);
  assign wrIntOsc  = wrPend & regHit(wrAddr, INT_OSC_MODE_IDX) & ~intLocked & curSrc;
  assign wrMainOsc = wrPend & regHit(wrAddr, MAIN_OSC_CTRL_IDX) & ~curSrc;
  assign wrStabSel = wrPend & regHit(wrAddr, STAB_SELECT_IDX);

  // Read multiplexer; unmapped words read zero
  assign rdValue =
    regHit(haddr, MAIN_CLOCK_MODE_IDX) ?
      32'((8'(hsClockFail) << FAIL_BIT) | (8'(curSrc) << STATUS_BIT) | 8'(selBit)) :
    regHit(haddr, INT_OSC_MODE_IDX)  ? 32'(8'(intStop) << INT_STOP_BIT) :
    regHit(haddr, MAIN_OSC_CTRL_IDX) ? 32'(8'(mainStop) << MAIN_STOP_BIT) :
    regHit(haddr, STAB_STATUS_IDX)   ? 32'(stabStatus) :
    regHit(haddr, STAB_SELECT_IDX)   ? 32'(stabSel) : 32'h0000_0000;

  // Address phase capture and zero-wait answer
  always_ff @(posedge clock) begin
    if (reset) begin
      wrPend    <= 1'b0;
      wrAddr    <= 32'h0000_0000;
      hrdata    <= 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wrPend    <= addrTaken & hwrite;
      wrAddr    <= haddr;
      hrdata    <= (addrTaken & ~hwrite) ? rdValue : 32'h0000_0000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Software control bits
  always_ff @(posedge clock) begin
    if (reset) begin
      selBit   <= SEL_RESET;
      intStop  <= INT_STOP_RESET;
      mainStop <= MAIN_STOP_RESET;
      stabSel  <= STAB_SEL_RESET;
    end else begin
      if (hsClockFail)
        selBit <= 1'b0;
      else if (wrMode)
        selBit <= hwdata[SEL_BIT];
      if (wrIntOsc)
        intStop <= hwdata[INT_STOP_BIT];
      if (wrMainOsc)
        mainStop <= hwdata[MAIN_STOP_BIT];
      if (wrStabSel)
        stabSel <= hwdata[2:0];
    end
  end

  // ------------------------------------------------------------
  // Oscillator enables
  // ------------------------------------------------------------
  logic hsRun;

  assign hsRun = ~mainStop & ~stopMode;

  // Enables held low through reset, internal one starts on release
  always_ff @(posedge clock) begin
    if (reset) begin
      hsXtalEnable <= 1'b0;
      hsRcEnable   <= 1'b0;
      intOscEnable <= 1'b0;
    end else begin
      hsXtalEnable <= hsRun & ~rcSel;
      hsRcEnable   <= hsRun & rcSel;
      intOscEnable <= ~(intStop & ~intLocked & curSrc);
    end
  end

  // ------------------------------------------------------------
  // Stabilization counter and status
  // ------------------------------------------------------------
  logic [16:0] stabCnt;
  logic [16:0] stabLimit;
  logic        stabDone;
  logic        stopPrev;
  logic        stabHold;

  assign stabLimit  = 17'h00001 << stabExp(stabSel);
  assign stabDone   = (stabCnt >= stabLimit);
  assign stabStatus = {stabCnt >= 17'h00800, stabCnt >= 17'h02000,
                       stabCnt >= 17'h04000, stabCnt >= 17'h08000,
                       stabCnt >= 17'h10000};

  // Count high-speed periods up to the selected time
  always_ff @(posedge clock) begin
    if (reset || mainStop || stopMode)
      stabCnt <= 17'h00000;
    else if (hsRise && !stabDone)
      stabCnt <= 17'(stabCnt + 17'h00001);
  end

  // Hold the CPU after STOP release on the high-speed source
  always_ff @(posedge clock) begin
    if (reset) begin
      stopPrev <= 1'b0;
      stabHold <= 1'b0;
    end else begin
      stopPrev <= stopMode;
      if (stopPrev && !stopMode && curSrc)
        stabHold <= 1'b1;
      else if (stabDone)
        stabHold <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // Clock monitor
  // ------------------------------------------------------------
  logic [7:0] monCnt;

  // Watch for missing high-speed edges once it has oscillated
  always_ff @(posedge clock) begin
    if (reset) begin
      monCnt      <= 8'h00;
      hsClockFail <= 1'b0;
    end else begin
      if (hsRise || !hsRun || !stabStatus[4])
        monCnt <= 8'h00;
      else if (monCnt != 8'(HS_MON_CYCLES))
        monCnt <= 8'(monCnt + 8'h01);
      if (monCnt == 8'(HS_MON_CYCLES))
        hsClockFail <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Start delay
  // ------------------------------------------------------------
  logic [4:0] startCnt;

  // CPU clock released after the set number of internal clocks
  always_ff @(posedge clock) begin
    if (reset) begin
      startCnt  <= 5'h00;
      cpuClkRun <= 1'b0;
    end else if (!cpuClkRun && intRise) begin
      startCnt <= 5'(startCnt + 5'h01);
      if (5'(startCnt + 5'h01) == CPU_START_INT_CLOCKS)
        cpuClkRun <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // Glitch-free source switch
  // ------------------------------------------------------------
  scc_switch_e swState;
  scc_switch_e next_swState;
  logic        curLvl;
  logic        newLvl;
  logic        cpuGate;
  logic        next_cpuClk;

  assign curLvl = curSrc ? hsLvl : intLvl;
  assign newLvl = selBit ? hsLvl : intLvl;

  // Next switch state
  always_comb begin
    next_swState = swState;
    case (swState)
      SW_RUN:   if (selBit != curSrc) next_swState = SW_DRAIN;
      SW_DRAIN: if (!curLvl) next_swState = SW_ARM;
      SW_ARM:   if (!newLvl) next_swState = SW_RUN;
      default:  next_swState = SW_RUN;
    endcase
  end

  // Old clock keeps running while draining, output low while arming
  always_comb begin
    case (swState)
      SW_RUN:   next_cpuClk = cpuGate & curLvl;
      SW_DRAIN: next_cpuClk = cpuGate & curLvl;
      default:  next_cpuClk = 1'b0;
    endcase
  end

  // Switch state, source status and gated clock outputs
  always_ff @(posedge clock) begin
    if (reset) begin
      swState      <= SW_RUN;
      curSrc       <= 1'b0;
      cpuGate      <= 1'b0;
      cpuClk       <= 1'b0;
      prescalerClk <= 1'b0;
    end else begin
      swState <= next_swState;
      if (swState == SW_ARM && !newLvl)
        curSrc <= selBit;
      if (!curLvl)
        cpuGate <= cpuClkRun & ~stabHold & ~stopMode;
      cpuClk       <= next_cpuClk;
      prescalerClk <= (swState == SW_ARM) ? 1'b0 : curLvl & ~stopMode;
    end
  end

endmodule

`default_nettype wire

/* scc_clock_source_assertions.sv */
`timescale 1ns/1ps
`default_nettype none

module scc_clock_source_assertions (
  input wire logic clock,
  input wire logic reset,
  input wire logic hsOscIn,
  input wire logic intOscIn,
  input wire logic hsXtalEnable,
  input wire logic hsRcEnable,
  input wire logic intOscEnable,
  input wire logic stopMode,
  input wire logic cpuClk,
  input wire logic cpuClkRun,
  input wire logic hsClockFail
);
  logic [4:0]  intCount;
  logic [11:0] hsEdges;
  logic [7:0]  hsIdle;
  wire         hsOn = (hsXtalEnable || hsRcEnable) && !stopMode;
  default clocking cb @(posedge clock);
  endclocking
  // Raw oscillator edge and idle counters
  always_ff @(posedge clock) begin
    if (reset) begin
      intCount <= 5'h00;
      hsEdges  <= 12'h000;
      hsIdle   <= 8'h00;
    end else begin
      if ($rose(intOscIn) && intCount != 5'h1F) intCount <= intCount + 5'h01;
      if (!hsOn) hsEdges <= 12'h000;
      else if ($rose(hsOscIn) && hsEdges != 12'h800) hsEdges <= hsEdges + 12'h001;
      if ($rose(hsOscIn)) hsIdle <= 8'h00;
      else if (hsIdle != 8'hFF) hsIdle <= hsIdle + 8'h01;
    end
  end
  // -------------------------------------------------
  // Properties
  // -------------------------------------------------
  sequence runStart;
    !cpuClkRun ##1 cpuClkRun;
  endsequence
  sequence hsDead;
    hsEdges == 12'h800 && hsIdle == 8'hC8 && hsOn;
  endsequence
  AST_RESET_STOPPED: assert property (reset |=> !intOscEnable && !hsXtalEnable && !hsRcEnable)
    else $error("oscillator enabled in reset");
  AST_INT_START: assert property (disable iff (reset) $fell(reset) |-> ##[0:1] intOscEnable)
    else $error("internal oscillator not started");
  AST_RUN_AFTER_17: assert property (disable iff (reset) runStart |-> intCount >= 5'h11)
    else $error("cpu clock started early");
  AST_CLK_WITHHELD: assert property (disable iff (reset) !cpuClkRun |-> !cpuClk)
    else $error("cpu clock not withheld");
  AST_NO_HS_WAIT: assert property (disable iff (reset) intCount == 5'h15 |-> cpuClkRun)
    else $error("cpu clock start late");
  AST_NO_RUNT: assert property (disable iff (reset) $changed(cpuClk) |=> $stable(cpuClk))
    else $error("truncated cpu clock pulse");
  AST_FAIL_CAUSE: assert property (disable iff (reset) $rose(hsClockFail) |-> hsIdle >= 8'h7D)
    else $error("clock fail without idle");
  AST_FAIL_DETECT: assert property (disable iff (reset) hsDead |-> hsClockFail)
    else $error("dead clock not detected");
  AST_ONE_SOURCE: assert property (disable iff (reset) !(hsXtalEnable && hsRcEnable))
    else $error("both high-speed sources on");
endmodule

bind scc_clock_source scc_clock_source_assertions u_scc_clock_source_assertions (
  .clock, .reset, .hsOscIn, .intOscIn, .hsXtalEnable, .hsRcEnable,
  .intOscEnable, .stopMode, .cpuClk, .cpuClkRun, .hsClockFail
);
`default_nettype wire

/* scc_osc_model.sv */
`timescale 1ns/1ps
`default_nettype none

module scc_osc_model #(
  parameter real HS_HALF_NS  = 20.3,
  parameter real INT_HALF_NS = 2083.3
) (
  input  wire logic xtalOn,
  input  wire logic rcOn,
  input  wire logic intOn,
  input  wire logic hsDead,
  output logic      hsOsc,
  output logic      intOsc
);
  // High-speed resonator, idles low when stopped or broken
  always begin
    hsOsc = 1'b0;
    wait ((xtalOn || rcOn) && !hsDead);
    #(HS_HALF_NS) hsOsc = 1'b1;
    #(HS_HALF_NS);
  end
  // Internal oscillator near its typical rate, silenced at once when disabled
  logic intRaw;
  assign intOsc = intRaw & intOn;
  always begin
    intRaw = 1'b0;
    wait (intOn);
    #(INT_HALF_NS) intRaw = 1'b1;
    #(INT_HALF_NS);
  end
endmodule
`default_nettype wire

/* scc_pkg.sv */
`default_nettype none

package scc_pkg;

  // ------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ------------------------------------------------------------
  localparam logic [15:0] MAIN_CLOCK_MODE_IDX = 16'hFFA0;
  localparam logic [15:0] INT_OSC_MODE_IDX    = 16'hFFA1;
  localparam logic [15:0] MAIN_OSC_CTRL_IDX   = 16'hFFA2;
  localparam logic [15:0] STAB_STATUS_IDX     = 16'hFFA3;
  localparam logic [15:0] STAB_SELECT_IDX     = 16'hFFA4;

  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int SEL_BIT       = 0;
  localparam int STATUS_BIT    = 1;
  localparam int FAIL_BIT      = 7;
  localparam int INT_STOP_BIT  = 0;
  localparam int MAIN_STOP_BIT = 7;

  // ------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------
  localparam logic       SEL_RESET       = 1'b0;
  localparam logic       INT_STOP_RESET  = 1'b0;
  localparam logic       MAIN_STOP_RESET = 1'b0;
  localparam logic [2:0] STAB_SEL_RESET  = 3'h5;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam logic [4:0] CPU_START_INT_CLOCKS = 5'h11;
  localparam int         CLOCK_MHZ            = 125;
  localparam int         HS_MON_TIME_NS       = 1000;
  localparam int         HS_MON_CYCLES        = HS_MON_TIME_NS * CLOCK_MHZ / 1000;

  // Switch sequencer states
  typedef enum logic [1:0] {
    SW_RUN,
    SW_DRAIN,
    SW_ARM
  } scc_switch_e;

  // Stabilization select code to exponent of the high-speed period
  function automatic logic [4:0] stabExp(input logic [2:0] sel);
    case (sel)
      3'h1:    stabExp = 5'h0B;
      3'h2:    stabExp = 5'h0D;
      3'h3:    stabExp = 5'h0E;
      3'h4:    stabExp = 5'h0F;
      default: stabExp = 5'h10;
    endcase
  endfunction

  // Word-address match for one register index
  function automatic logic regHit(input logic [31:0] addr, input logic [15:0] idx);
    regHit = (addr[17:0] == {idx, 2'b00});
  endfunction

endpackage

`default_nettype wire

/* tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
  import scc_pkg::*;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0]  htrans = 2'h0;
  logic        hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic        optRc = 1'b0;
  logic        optLock = 1'b1;
  logic        stopMode = 1'b0;
  logic        hsDead = 1'b0;
  logic        hreadyout, hresp, hsOscIn, intOscIn, hsXtalEnable, hsRcEnable;
  logic        intOscEnable, cpuClk, prescalerClk, cpuClkRun, hsClockFail;
  logic [31:0] hrdata;
  int          miscompares = 0;
  int          checksDone = 0;
  always #4 clock = ~clock;
  scc_clock_source u_scc_clock_source (
    .clock, .reset, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2), .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .hsOscIn, .intOscIn,
    .optRcSelect(optRc), .optIntOscLocked(optLock), .hsXtalEnable, .hsRcEnable,
    .intOscEnable, .stopMode, .cpuClk, .prescalerClk, .cpuClkRun, .hsClockFail
  );
  scc_osc_model u_scc_osc_model (
    .xtalOn(hsXtalEnable), .rcOn(hsRcEnable), .intOn(intOscEnable), .hsDead,
    .hsOsc(hsOscIn), .intOsc(intOscIn)
  );
  // -------------------------------------------------
  // Bus and compare tasks
  // -------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      miscompares++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic [15:0] idx, input logic wr, input logic [31:0] d,
                     output logic [31:0] q);
    @(posedge clock);
    hsel   <= 1'b1;
    haddr  <= {14'h0, idx, 2'h0};
    htrans <= 2'h2;
    hwrite <= wr;
    do @(posedge clock); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic wr(input logic [15:0] idx, input logic [31:0] d);
    logic [31:0] q;
    bus(idx, 1'b1, d, q);
  endtask
  task automatic rdIs(input logic [15:0] idx, input logic [31:0] exp);
    logic [31:0] q;
    bus(idx, 1'b0, 32'h0, q);
    chk(q, exp);
    chk(hresp, 1'b0);
  endtask
  task automatic pollFor(input logic [15:0] idx, input logic [31:0] m, input logic [31:0] v);
    logic [31:0] q;
    q = ~v & m;
    for (int i = 0; i < 6000 && (q & m) !== v; i++) bus(idx, 1'b0, 32'h0, q);
  endtask
  task automatic doReset(input logic rc);
    optRc <= rc;
    reset <= 1'b1;
    repeat (5) @(posedge clock);
    chk({intOscEnable, hsXtalEnable, hsRcEnable}, 3'h0);
    reset <= 1'b0;
  endtask
  // -------------------------------------------------
  // Scenarios
  // -------------------------------------------------
  task automatic testStart;
    int n;
    logic last;
    n = 0;
    last = 1'b0;
    rdIs(MAIN_CLOCK_MODE_IDX, 32'h0);
    rdIs(STAB_SELECT_IDX, 32'h5);
    while (cpuClkRun !== 1'b1) begin
      @(posedge clock);
      if (intOscIn === 1'b1 && !last) n++;
      last = intOscIn;
    end
    chk(n, 17);
    chk(intOscEnable, 1'b1);
    rdIs(STAB_STATUS_IDX, 32'h0);
  endtask
  task automatic testRefuse;
    wr(INT_OSC_MODE_IDX, 32'h1);
    rdIs(INT_OSC_MODE_IDX, 32'h0);
    rdIs(16'hFFA7, 32'h0);
    rdIs(MAIN_CLOCK_MODE_IDX, 32'h0);
    wr(MAIN_OSC_CTRL_IDX, 32'h80);
    rdIs(MAIN_OSC_CTRL_IDX, 32'h80);
    chk(hsXtalEnable, 1'b0);
    wr(MAIN_OSC_CTRL_IDX, 32'h0);
  endtask
  task automatic testSwitch;
    int n;
    logic last;
    n = 0;
    pollFor(STAB_STATUS_IDX, 32'h10, 32'h10);
    rdIs(STAB_STATUS_IDX, 32'h10);
    wr(MAIN_CLOCK_MODE_IDX, 32'h1);
    pollFor(MAIN_CLOCK_MODE_IDX, 32'h2, 32'h2);
    rdIs(MAIN_CLOCK_MODE_IDX, 32'h3);
    last = prescalerClk;
    repeat (203) begin
      @(posedge clock);
      if (prescalerClk === 1'b1 && last !== 1'b1) n++;
      last = prescalerClk;
    end
    chk(n inside {[39:41]}, 1'b1);
  endtask
  task automatic testIntStop;
    rdIs(MAIN_CLOCK_MODE_IDX, 32'h3);
    wr(INT_OSC_MODE_IDX, 32'h1);
    rdIs(INT_OSC_MODE_IDX, 32'h0);
    optLock <= 1'b0;
    repeat (4) @(posedge clock);
    wr(INT_OSC_MODE_IDX, 32'h1);
    rdIs(INT_OSC_MODE_IDX, 32'h1);
    chk(intOscEnable, 1'b0);
    wr(INT_OSC_MODE_IDX, 32'h0);
    wr(MAIN_OSC_CTRL_IDX, 32'h80);
    rdIs(MAIN_OSC_CTRL_IDX, 32'h0);
    chk({intOscEnable, hsXtalEnable}, 2'h3);
  endtask
  task automatic testStop;
    int n;
    n = 0;
    wr(STAB_SELECT_IDX, 32'h1);
    stopMode <= 1'b1;
    repeat (20) @(posedge clock);
    stopMode <= 1'b0;
    @(posedge clock);
    while (cpuClk !== 1'b1 && n < 20000) begin
      @(posedge clock);
      n++;
    end
    chk(n >= 10350 && n < 11000, 1'b1);
    rdIs(STAB_STATUS_IDX, 32'h10);
  endtask
  task automatic testFail;
    hsDead <= 1'b1;
    repeat (400) @(posedge clock);
    chk(hsClockFail, 1'b1);
    pollFor(MAIN_CLOCK_MODE_IDX, 32'h2, 32'h0);
    rdIs(MAIN_CLOCK_MODE_IDX, 32'h80);
    hsDead <= 1'b0;
    doReset(1'b1);
    repeat (6) @(posedge clock);
    chk({hsRcEnable, hsXtalEnable}, 2'h2);
  endtask
  task automatic testRcStart;
    rdIs(STAB_STATUS_IDX, 32'h0);
    wr(MAIN_CLOCK_MODE_IDX, 32'h1);
    pollFor(MAIN_CLOCK_MODE_IDX, 32'h2, 32'h2);
    rdIs(MAIN_CLOCK_MODE_IDX, 32'h3);
    chk(hsRcEnable, 1'b1);
    wr(MAIN_CLOCK_MODE_IDX, 32'h0);
    pollFor(MAIN_CLOCK_MODE_IDX, 32'h2, 32'h0);
    stopMode <= 1'b1;
    repeat (20) @(posedge clock);
    stopMode <= 1'b0;
    pollFor(STAB_STATUS_IDX, 32'h10, 32'h10);
    rdIs(STAB_STATUS_IDX, 32'h10);
  endtask
  task automatic reportAndStop;
    $display("checks %0d mismatches %0d", checksDone, miscompares);
    if (miscompares == 0 && checksDone > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Main sequence
  initial begin
    doReset(1'b0);
    testStart();
    testRefuse();
    testSwitch();
    testIntStop();
    testStop();
    testFail();
    testRcStart();
    reportAndStop();
  end
  // Watchdog against hangs
  initial begin
    repeat (90000) @(posedge clock);
    miscompares++;
    reportAndStop();
  end
endmodule
`default_nettype wire
